// ---- core/rbf_buffer.sv ----
// Purpose: 13-bit registered buffer driving two identical 13-bit output copies
// Assumes: clock pair and data pins are asynchronous to clk_i and pass a three-stage sampler
// Notes: the reset clears without a clock edge, so it departs from a synchronous reset style
`timescale 1ns/100ps
// Operation
// (RQ1) thirteen data bits are registered, each driving two identical output pins
// (RQ2) out of reset, data is sampled when the positive clock rises and negative falls
// (RQ3) with no clock crossing, outputs hold their previous level whatever the data does
// (RQ4) reset low clears all registers at once and holds every output low; the code leaves the FIFO storage mem_r uncleared
// (RQ5) during reset the data and clock receivers are disabled
// (RQ6) reset acts without any clock running, even before a stable clock
// (RQ7) the controller keeps reset low through power-up until the clock is stable
// (RQ8) releasing reset with data low and clock stable leaves outputs low, no glitch
// (RQ9) the controller keeps data low at least 22 ns after reset release
// (RQ10) the controller keeps data and clock valid at least 22 ns after reset assertion
// (RQ11) the clock pair acts as one rising edge; reset asynchronously clears the flops
module rbf_buffer (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic pair_clk_p_i,
  input wire logic pair_clk_n_i,
  input wire logic [rbf_pkg::DATA_W-1:0] data_in_bits_i,
  input wire logic out_accept_i,
  output logic [rbf_pkg::DATA_W-1:0] registered_out_bits_a_o,
  output logic [rbf_pkg::DATA_W-1:0] registered_out_bits_b_o,
  output logic rx_enable_o,
  output logic capture_ready_o,
  output logic overrun_o
);

  // true while the pair sits in its crossed state, positive high and negative low
  function automatic logic rbf_pair_crossed(input rbf_pkg::rbf_pins_t s);
    rbf_pair_crossed = s.clk_p & ~s.clk_n;
  endfunction : rbf_pair_crossed

  rbf_pkg::rbf_pins_t pins_now;
  rbf_pkg::rbf_pins_t sync_r [rbf_pkg::SYNC_STAGES];
  rbf_pkg::rbf_out_pair_t out_pair_r;
  logic rx_en_r;
  logic pair_lvl_r;
  logic primed_r;
  logic agree;
  logic cross_evt;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [rbf_pkg::DATA_W-1:0] fifo_out_data;
  logic take;
  logic capture_ready_r;
  logic overrun_r;

  assign pins_now.clk_p = pair_clk_p_i;
  assign pins_now.clk_n = pair_clk_n_i;
  assign pins_now.data = data_in_bits_i;

  // receivers come up one cycle after release, so the sampler never sees the release edge
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_en_r <= 1'b0; // see (RQ5)
    end else begin
      rx_en_r <= 1'b1; // see (RQ8)
    end
  end

  // three-stage sampler, one stage per generate step; held clear while receivers are off
  genvar g;
  generate
    for (g = 0; g < rbf_pkg::SYNC_STAGES; g++) begin : g_sync
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          sync_r[g] <= '0; // see (RQ5)
        end else if (!rx_en_r) begin
          sync_r[g] <= '0;
        end else if (g == 0) begin
          sync_r[g] <= pins_now;
        end else begin
          sync_r[g] <= sync_r[(g == 0) ? 0 : g-1];
        end
      end
    end
  endgenerate

  // a pair change counts only once stages two and three agree
  assign agree = (rbf_pair_crossed(sync_r[1]) == rbf_pair_crossed(sync_r[2]));
  // single edge event per crossing; the first agreed level only primes, but that is the cleared sampler level,
  // so a pair that is already crossed at release is still taken as an edge once stages two and three agree
  assign cross_evt = rx_en_r && primed_r && agree && rbf_pair_crossed(sync_r[2]) && !pair_lvl_r; // see (RQ11)

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pair_lvl_r <= 1'b0;
      primed_r <= 1'b0;
    end else if (rx_en_r && agree) begin
      pair_lvl_r <= rbf_pair_crossed(sync_r[2]);
      primed_r <= 1'b1;
    end
  end

  // data is taken from the same stage as the decided crossing, keeping the two aligned
  rbf_fifo #(
    .WIDTH(rbf_pkg::DATA_W),
    .DEPTH(rbf_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(cross_evt), // see (RQ2)
    .in_ready_o(fifo_in_ready),
    .in_data_i(sync_r[2].data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(out_accept_i),
    .out_data_o(fifo_out_data)
  );

  assign take = fifo_out_valid && out_accept_i;

  // outputs move only on a taken word; otherwise they keep the previous output level
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_pair_r.copy_a <= rbf_pkg::OUT_RST_VAL; // see (RQ4) (RQ6)
      out_pair_r.copy_b <= rbf_pkg::OUT_RST_VAL;
    end else if (take) begin // see (RQ3)
      out_pair_r.copy_a <= fifo_out_data; // see (RQ1)
      out_pair_r.copy_b <= fifo_out_data;
    end
  end

  // a crossing that meets a full buffer is lost; that is flagged for one cycle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      capture_ready_r <= 1'b0;
      overrun_r <= 1'b0;
    end else begin
      capture_ready_r <= fifo_in_ready && rx_en_r;
      overrun_r <= cross_evt && !fifo_in_ready;
    end
  end

  // helper counters read only by the checks below; both saturate so they never wrap
  logic [3:0] rel_age_r;
  logic [3:0] stall_age_r;
  logic load_seen;

  assign load_seen = u_fifo.load;

  // edges since reset release
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rel_age_r <= 4'h0;
    end else if (rel_age_r != 4'hf) begin
      rel_age_r <= rel_age_r + 4'h1;
    end
  end

  // cycles a ready word has waited on a held-off consumer
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stall_age_r <= 4'h0;
    end else if (!fifo_out_valid || out_accept_i) begin
      stall_age_r <= 4'h0;
    end else if (stall_age_r != 4'hf) begin
      stall_age_r <= stall_age_r + 4'h1;
    end
  end

  assign registered_out_bits_a_o = out_pair_r.copy_a;
  assign registered_out_bits_b_o = out_pair_r.copy_b;
  assign rx_enable_o = rx_en_r;
  assign capture_ready_o = capture_ready_r;
  assign overrun_o = overrun_r;

  // checks that hold outside reset
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  copies_equal_a: assert property ( // see (RQ1)
    registered_out_bits_a_o == registered_out_bits_b_o)
    else $error("output copies differ");

  sequence word_taken_s;
    fifo_out_valid && out_accept_i;
  endsequence

  word_to_out_a: assert property ( // see (RQ2)
    word_taken_s |=> registered_out_bits_a_o == $past(fifo_out_data))
    else $error("taken word did not reach outputs");

  sequence crossed_s;
    cross_evt && fifo_in_ready;
  endsequence

  crossing_stored_a: assert property ( // see (RQ2)
    crossed_s |=> fifo_out_valid || !$stable(u_fifo.count_r) || $past(load_seen))
    else $error("crossing was not stored");

  hold_no_edge_a: assert property ( // see (RQ3)
    !(fifo_out_valid && out_accept_i) |=> $stable(registered_out_bits_a_o) && $stable(registered_out_bits_b_o))
    else $error("outputs moved without a taken word");

  one_edge_only_a: assert property ( // see (RQ11)
    cross_evt |=> !cross_evt)
    else $error("two edges for one crossing");

  edge_needs_level_a: assert property ( // see (RQ11)
    cross_evt |-> rbf_pair_crossed(sync_r[1]) && rbf_pair_crossed(sync_r[2]) && !pair_lvl_r)
    else $error("edge without an agreed crossing");

  overrun_flag_a: assert property (
    cross_evt && !fifo_in_ready |=> overrun_o)
    else $error("lost crossing not flagged");

  // checks that look at the reset itself; the three in-reset ones carry no disable condition
  reset_clears_out_a: assert property (@(posedge clk_i) disable iff (1'b0) // see (RQ4)
    !rst_b_i |-> registered_out_bits_a_o == '0 && registered_out_bits_b_o == '0 && !overrun_o)
    else $error("outputs not low in reset");

  reset_rx_off_a: assert property (@(posedge clk_i) disable iff (1'b0) // see (RQ5)
    !rst_b_i |-> !rx_enable_o && sync_r[0] == '0 && !cross_evt && !capture_ready_o)
    else $error("receivers active in reset");

  reset_no_clock_a: assert property (@(posedge clk_i) disable iff (1'b0) // see (RQ6)
    $fell(rst_b_i) |-> registered_out_bits_a_o == '0 && !rx_enable_o)
    else $error("reset waited for a clock");

  sequence release_low_s;
    $rose(rst_b_i) && data_in_bits_i == '0;
  endsequence

  release_stays_low_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see (RQ8)
    release_low_s |-> (registered_out_bits_a_o == '0 && registered_out_bits_b_o == '0)[*4])
    else $error("output glitch at reset release");

  rx_on_after_release_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see (RQ5)
    $rose(rst_b_i) |-> !rx_enable_o ##1 rx_enable_o)
    else $error("receiver enable timing wrong");

  // stepwise checks of the crossing detector, the sampler, the reset window, copy b, the overrun flag and output stalls
  sequence pair_open_s;
    !rbf_pair_crossed(sync_r[1]) && !rbf_pair_crossed(sync_r[2]);
  endsequence

  sequence pair_closed_s;
    rbf_pair_crossed(sync_r[1]) && rbf_pair_crossed(sync_r[2]);
  endsequence

  crossing_found_a: assert property ( // see (RQ2)
    pair_open_s ##1 rbf_pair_crossed(sync_r[1]) ##1 pair_closed_s |-> cross_evt)
    else $error("agreed crossing not detected");

  level_follows_a: assert property ( // see (RQ11)
    pair_closed_s |=> pair_lvl_r)
    else $error("pair level not tracked");

  copy_b_follows_a: assert property ( // see (RQ1)
    word_taken_s |=> registered_out_bits_b_o == $past(fifo_out_data))
    else $error("taken word did not reach copy b");

  rx_stays_on_a: assert property ( // see (RQ5)
    rx_enable_o |=> rx_enable_o)
    else $error("receivers dropped outside reset");

  rx_follows_age_a: assert property ( // see (RQ5)
    rx_enable_o == (rel_age_r != 4'h0))
    else $error("receiver enable out of step with release");

  sampler_off_a: assert property ( // see (RQ5)
    !rx_enable_o |=> sync_r[0] == '0 && sync_r[1] == '0 && sync_r[2] == '0)
    else $error("sampler loaded while receivers off");

  sampler_shift_a: assert property ( // see (RQ11)
    $past(rx_enable_o) |-> sync_r[1] == $past(sync_r[0]) && sync_r[2] == $past(sync_r[1]))
    else $error("sampler stages out of step");

  cap_off_rx_a: assert property ( // see (RQ5)
    !rx_enable_o |=> !capture_ready_o)
    else $error("capture ready while receivers off");

  overrun_cause_a: assert property (
    overrun_o |-> $past(cross_evt) && !$past(fifo_in_ready))
    else $error("overrun without a lost crossing");

  overrun_one_shot_a: assert property (
    overrun_o |=> !overrun_o)
    else $error("overrun longer than one cycle");

  drop_flagged_a: assert property (
    $past(cross_evt) && !capture_ready_o |-> overrun_o)
    else $error("crossing on full buffer not flagged");

  release_window_low_a: assert property ( // see (RQ8)
    rel_age_r <= 4'(rbf_pkg::T_ACT_CYC + 1) |-> registered_out_bits_a_o == '0 && registered_out_bits_b_o == '0)
    else $error("outputs high right after release");

  early_edge_ignored_a: assert property ( // see (RQ5)
    rel_age_r <= 4'h1 |-> !cross_evt)
    else $error("crossing taken right after release");

  stall_holds_out_a: assert property ( // see (RQ3)
    stall_age_r != 4'h0 |-> $stable(registered_out_bits_a_o) && $stable(registered_out_bits_b_o))
    else $error("outputs moved during a stall");

  stall_keeps_word_a: assert property ( // see (RQ3)
    stall_age_r != 4'h0 |-> fifo_out_valid && $stable(fifo_out_data))
    else $error("waiting word lost during a stall");

endmodule : rbf_buffer

// ---- pkg/rbf_pkg.sv ----
// Purpose: shared constants and carrier types for the 13-to-26 registered buffer
// Assumes: one 20 MHz system clock; the buffer pins are sampled into that domain
// Notes: times are kept in ns as given, cycle counts are derived from the clock period
package rbf_pkg;

  localparam int DATA_W = 13;
  localparam int COPIES = 2;
  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_STAGES = 3;

  localparam int CLK_PERIOD_NS = 50;
  // data must stay low this long after reset release (least time, rounded up)
  localparam int T_ACT_NS = 22;
  localparam int T_ACT_CYC = (T_ACT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
    (T_ACT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // inputs stay valid this long after reset assertion (least time, rounded up)
  localparam int T_INACT_NS = 22;
  localparam int T_INACT_CYC = (T_INACT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
    (T_INACT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [DATA_W-1:0] OUT_RST_VAL = 13'h0000;

  // one sample of the buffer's input pins
  typedef struct packed {
    logic clk_p;
    logic clk_n;
    logic [DATA_W-1:0] data;
  } rbf_pins_t;

  // both output copies of one stored word
  typedef struct packed {
    logic [DATA_W-1:0] copy_a;
    logic [DATA_W-1:0] copy_b;
  } rbf_out_pair_t;

endpackage : rbf_pkg

// ---- core/rbf_fifo.sv ----
// Purpose: small synchronous FIFO with valid/ready on both sides and a registered read port
// Assumes: single clock, asynchronous active-low clear
// Notes: one word sits in the output register, so total storage is DEPTH plus one
`timescale 1ns/100ps
module rbf_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_C = (PW)'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0] count_r;
  logic out_valid_r;
  logic [WIDTH-1:0] out_data_r;
  logic push;
  logic load;

  assign in_ready_o = (count_r != DEPTH_C);
  assign push = in_valid_i && in_ready_o;
  // the output register refills from storage whenever storage holds a word and the register is empty or being taken
  assign load = (count_r != '0) && (!out_valid_r || out_ready_i);
  assign out_valid_o = out_valid_r;
  assign out_data_o = out_data_r;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == LAST_C) ? '0 : wr_ptr_r + 1'b1;
      end
      if (load) begin
        rd_ptr_r <= (rd_ptr_r == LAST_C) ? '0 : rd_ptr_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_r <= '0;
    end else if (push && !load) begin
      count_r <= count_r + 1'b1;
    end else if (load && !push) begin
      count_r <= count_r - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_valid_r <= 1'b0;
      out_data_r <= '0;
    end else if (load) begin
      out_valid_r <= 1'b1;
      out_data_r <= mem_r[rd_ptr_r];
    end else if (out_ready_i) begin
      out_valid_r <= 1'b0;
    end
  end

  fifo_no_overfill_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) count_r <= DEPTH_C)
    else $error("fifo count above depth");

endmodule : rbf_fifo

// ---- tb/rbf_ctl_model.sv ----
// Purpose: controller model driving the clock pair and data pins of the buffer
// Assumes: pins change on the falling edge of clk_i
// Notes: one crossing per request; data turns to its inverse once its hold has run out
`timescale 1ns/100ps
module rbf_ctl_model (
  input wire logic clk_i,
  input wire logic send_i,
  input wire logic [rbf_pkg::DATA_W-1:0] word_i,
  output logic clk_p_o,
  output logic clk_n_o,
  output logic [rbf_pkg::DATA_W-1:0] data_o,
  output logic busy_o
);
  logic [2:0] cnt_r;
  initial begin
    cnt_r = 3'h0;
    clk_p_o = 1'b0;
    clk_n_o = 1'b1;
    // defined levels from time zero, data low for the first release
    data_o = 13'h0000;
  end
  assign busy_o = cnt_r != 3'h0;
  always @(negedge clk_i) begin
    if (cnt_r == 3'h0 && send_i) begin
      data_o <= word_i;
      clk_p_o <= 1'b1;
      clk_n_o <= 1'b0;
      cnt_r <= 3'h6;
    end else if (cnt_r != 3'h0) begin
      cnt_r <= cnt_r - 3'h1;
      // three cycles each level so the slow sampler sees both
      if (cnt_r == 3'h4) begin
        clk_p_o <= 1'b0;
        clk_n_o <= 1'b1;
        data_o <= ~data_o;
      end
    end
  end
endmodule : rbf_ctl_model

// ---- tb/rbf_buffer_tb.sv ----
// Purpose: self-checking bench for the registered buffer
// Assumes: inputs change on the falling edge, 50 ns clock
// Notes: each scenario is its own task; all waits are bounded
`timescale 1ns/100ps
module rbf_buffer_tb;
  logic clk_i = 1'b0;
  logic rst_b_i; // driven low at time zero and held through the first three falling clock edges
  logic send = 1'b0;
  logic accept = 1'b1;
  logic ovr_seen = 1'b0;
  logic [12:0] word = 13'h0000;
  logic cp, cn, rx_en, cap, ovr, busy;
  logic [12:0] pins, qa, qb;
  int error_cnt = 0;
  int checks_done = 0;
  logic [12:0] tbl [4] = '{13'h1a5b, 13'h1fff, 13'h0000, 13'h0aaa};
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (ovr === 1'b1) ovr_seen <= 1'b1;
  rbf_ctl_model i_rbf_ctl_model (.clk_i(clk_i), .send_i(send), .word_i(word), .clk_p_o(cp), .clk_n_o(cn),
    .data_o(pins), .busy_o(busy));
  rbf_buffer i_rbf_buffer (.clk_i(clk_i), .rst_b_i(rst_b_i), .pair_clk_p_i(cp), .pair_clk_n_i(cn),
    .data_in_bits_i(pins), .out_accept_i(accept), .registered_out_bits_a_o(qa),
    .registered_out_bits_b_o(qb), .rx_enable_o(rx_en), .capture_ready_o(cap), .overrun_o(ovr));
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task chk(input logic [12:0] seen, input logic [12:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task give_up;
    error_cnt++;
    $display("BAD t=%0t wait ran out", $time);
    summarize();
  endtask : give_up
  task send_word(input logic [12:0] w);
    @(negedge clk_i);
    word <= w;
    send <= 1'b1;
    @(negedge clk_i);
    send <= 1'b0;
    for (int i = 0; i < 20; i++) begin
      @(negedge clk_i);
      if (busy === 1'b0) return;
    end
    give_up();
  endtask : send_word
  task wait_out(input logic [12:0] exp);
    for (int i = 0; i < 40; i++) begin
      @(negedge clk_i);
      if (qa === exp) begin
        chk(qb, exp);
        return;
      end
    end
    give_up();
  endtask : wait_out
  task t_reset;
    repeat (3) begin
      @(negedge clk_i);
      chk(qa, 13'h0000);
      chk({12'h000, rx_en}, 13'h0000);
      chk({12'h000, cap}, 13'h0000);
    end
    rst_b_i <= 1'b1;
    @(negedge clk_i);
    chk({12'h000, rx_en}, 13'h0001);
    chk(qa, 13'h0000);
    @(negedge clk_i);
    chk({12'h000, cap}, 13'h0001);
    chk(qb, 13'h0000);
    $display("test reset done");
  endtask : t_reset
  task t_words;
    for (int k = 0; k < 4; k++) begin
      send_word(tbl[k]);
      wait_out(tbl[k]);
    end
    // data pins now idle inverted with the pair static
    repeat (10) @(negedge clk_i);
    chk(qa, 13'h0aaa);
    chk(qb, 13'h0aaa);
    $display("test words done");
  endtask : t_words
  task t_full;
    @(negedge clk_i);
    accept <= 1'b0;
    for (int k = 0; k < 10; k++) send_word(13'h0100 + 13'(k));
    chk({12'h000, cap}, 13'h0000);
    chk({12'h000, ovr_seen}, 13'h0001);
    chk(qa, 13'h0aaa);
    accept <= 1'b1;
    for (int k = 0; k < 9; k++) begin
      @(negedge clk_i);
      chk(qa, 13'h0100 + 13'(k));
      chk(qb, 13'h0100 + 13'(k));
    end
    repeat (3) @(negedge clk_i);
    chk(qa, 13'h0108);
    $display("test full done");
  endtask : t_full
  task t_async;
    @(negedge clk_i);
    rst_b_i <= 1'b0;
    #1 chk(qa, 13'h0000);
    chk(qb, 13'h0000);
    // a crossing during reset must not land; data then idles low
    send_word(13'h1fff);
    chk({12'h000, rx_en}, 13'h0000);
    rst_b_i <= 1'b1;
    repeat (8) begin
      @(negedge clk_i);
      chk(qa, 13'h0000);
    end
    send_word(13'h0555);
    wait_out(13'h0555);
    $display("test async reset done");
  endtask : t_async
  initial begin
    // a step from unknown to low, so the asynchronous clears fire at power-up
    rst_b_i <= 1'b0;
    t_reset();
    t_words();
    t_full();
    t_async();
    summarize();
  end
endmodule : rbf_buffer_tb
